// >>> dv/scfc_led_model.sv
/*
 * Behavioural model of the LED on the sink and of the on-timer beside it.
 * Assumes it shares the block clock; pulses on-done once per ON phase.
 */
`timescale 1ns/1ps
`default_nettype none

module scfc_led_model #(
   parameter int ON_CYCLES = 20
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic [6:0] i_sink_code,
   input  wire logic       i_sink_on,
   output logic            o_on_done,
   output logic            o_lit
);
   int cnt;
   // Driven on the falling edge so the block samples a settled pulse
   always @(negedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt       <= 0;
         o_on_done <= 1'b0;
      end else begin
         o_on_done <= i_sink_on && (cnt == ON_CYCLES - 1);
         cnt       <= i_sink_on ? cnt + 1 : 0;
      end
   end
   assign o_lit = (i_sink_code != 7'h00);
endmodule

`default_nettype wire

// >>> dv/tb_top.sv
/*
 * Self-checking bench for the sink fade and current control block.
 * Assumes shortened counts: two cycles per fade step unit, four per off step.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   localparam int FS = 2;
   localparam int OS = 4;
   logic               clk;
   logic               rst;
   scfc_pkg::scfc_wr_t wr;
   scfc_pkg::scfc_rd_t rd;
   logic               sink_en;
   logic [6:0]         off_time;
   logic               on_done;
   logic               lit;
   logic [7:0]         rd_data;
   logic               rd_valid;
   logic [6:0]         code;
   logic               sink_on;
   logic               held_off;
   int                 miscompares;
   int                 checked;

   scfc_top #(.FADE_STEP_CYCLES(FS), .OFF_STEP_CYCLES(OS)) dut_u (
      .i_clk(clk), .i_rst(rst), .i_wr(wr), .i_rd(rd), .i_sink_en(sink_en),
      .i_sink_off_time(off_time), .i_on_done(on_done), .o_rd_data(rd_data),
      .o_rd_valid(rd_valid), .o_sink_code(code), .o_sink_on(sink_on),
      .o_sink_held_off(held_off));
   scfc_led_model #(.ON_CYCLES(20)) led_u (
      .i_clk(clk), .i_rst(rst), .i_sink_code(code), .i_sink_on(sink_on),
      .o_on_done(on_done), .o_lit(lit));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic near(input int got, input int exp, input int tol);
      checked++;
      if (got < exp - tol || got > exp + tol) begin
         miscompares++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      wr = '{en: 1'b1, addr: a, data: d};
      @(negedge clk);
      wr.en = 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      rd = '{en: 1'b1, addr: a};
      @(negedge clk);
      rd.en = 1'b0;
      chk({7'h00, rd_valid}, 8'h01);
      chk(rd_data, exp);
   endtask

   task automatic cycles(input int n);
      repeat (n) @(negedge clk);
   endtask

   function automatic int units(input int c);
      return (c <= 10) ? c : 15 + 5 * (c - 11);
   endfunction

   task automatic test_regs();
      reg_rd(8'h22, 8'h00);
      reg_rd(8'h23, 8'h00);
      reg_rd(8'h30, 8'h00);
      reg_wr(8'h22, 8'h5A);
      reg_wr(8'h23, 8'hFF);
      reg_wr(8'h30, 8'h33);
      reg_rd(8'h22, 8'h5A);
      reg_rd(8'h23, 8'h7F);
      reg_rd(8'h30, 8'h00);
      $display("test regs done");
   endtask

   task automatic test_no_fade();
      int n;
      n = 0;
      reg_wr(8'h22, 8'h00);
      reg_wr(8'h23, 8'h40);
      off_time = 7'h00;
      sink_en  = 1'b1;
      cycles(2);
      chk({1'b0, code}, 8'h40);
      for (int i = 0; i < 60; i++) begin
         @(negedge clk);
         n += (sink_on === 1'b1) ? 0 : 1;
      end
      chk(n[7:0], 8'h00);
      sink_en = 1'b0;
      cycles(2);
      chk({1'b0, code}, 8'h00);
      $display("test no fade done");
   endtask

   // Time to walk lvl codes; the same slope from any level, up or down
   task automatic fade_case(input int ci, input int co, input logic [6:0] lvl);
      int n;
      reg_wr(8'h22, {4'(co), 4'(ci)});
      reg_wr(8'h23, {1'b0, lvl});
      sink_en = 1'b1;
      n = 0;
      while (code !== lvl && n < 20000) begin
         @(negedge clk);
         n++;
      end
      near(n, units(ci) * FS * lvl, units(ci) * FS + 3);
      sink_en = 1'b0;
      n = 0;
      while (code !== 7'h00 && n < 20000) begin
         @(negedge clk);
         n++;
      end
      near(n, units(co) * FS * lvl, units(co) * FS + 3);
   endtask

   task automatic test_fades();
      off_time = 7'h00;
      for (int c = 1; c < 16; c++) begin
         fade_case(16 - c, c, 7'h10);
      end
      fade_case(1, 2, 7'h7F);
      $display("test fades done");
   endtask

   task automatic wait_fall(output int n);
      n = 0;
      while (sink_on !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      while (sink_on === 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
   endtask

   task automatic test_blink();
      int n;
      reg_wr(8'h22, 8'h00);
      reg_wr(8'h23, 8'h20);
      off_time = 7'h03;
      sink_en  = 1'b1;
      wait_fall(n);
      @(negedge clk);
      chk({1'b0, code}, 8'h00);
      n = 1;
      while (sink_on !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      near(n, 2 * OS + 1, 1);
      // Zero off time only with a non-zero fade-out
      reg_wr(8'h22, 8'h10);
      off_time = 7'h01;
      wait_fall(n);
      n = 0;
      while (sink_on !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      near(n, 1, 0);
      reg_wr(8'h22, 8'h00);
      off_time = 7'h7F;
      wait_fall(n);
      cycles(60);
      chk({5'h00, held_off, sink_on, lit}, 8'h04);
      sink_en = 1'b0;
      cycles(2);
      chk({7'h00, held_off}, 8'h00);
      $display("test blink done");
   endtask

   initial begin
      miscompares = 0;
      checked     = 0;
      wr          = '{en: 1'b0, addr: 8'h00, data: 8'h00};
      rd          = '{en: 1'b0, addr: 8'h00};
      sink_en     = 1'b0;
      off_time    = 7'h00;
      rst         = 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      test_regs();
      test_no_fade();
      test_fades();
      test_blink();
      final_report();
   end

   // Tests need about 13000 cycles
   initial begin
      #(60000 * 100);
      miscompares++;
      final_report();
   end
endmodule

`default_nettype wire

// >>> hw/scfc_pkg.sv
/*
 * Shared constants, types and decode helpers for the sink fade and
 * current control block.
 * Assumes a 10 MHz core clock; register traffic arrives already decoded
 * from the serial control interface as byte-wide read and write requests.
 */
`default_nettype none

package scfc_pkg;

   // Register map
   localparam logic [7:0] ADDR_FADE_TIMES  = 8'h22;
   localparam logic [7:0] ADDR_LED1_CURR   = 8'h23;

   // Field positions
   localparam int         FADE_OUT_MSB     = 7;
   localparam int         FADE_OUT_LSB     = 4;
   localparam int         FADE_IN_MSB      = 3;
   localparam int         FADE_IN_LSB      = 0;
   localparam int         CURR_CODE_MSB    = 6;

   // Reset values and unmapped read data
   localparam logic [7:0] FADE_TIMES_RST   = 8'h00;
   localparam logic [6:0] LED1_CODE_RST    = 7'h00;
   localparam logic [7:0] RDATA_UNMAPPED   = 8'h00;

   // Fade code table
   localparam logic [3:0] FADE_DISABLED    = 4'h0;
   localparam logic [3:0] FADE_LIN_LAST    = 4'hA;
   localparam logic [5:0] FADE_COARSE_BASE = 6'h0F;
   localparam logic [5:0] FADE_COARSE_STEP = 6'h05;
   localparam logic [5:0] FADE_COARSE_FROM = 6'h0B;
   localparam logic [6:0] FULL_SCALE_CODE  = 7'h7F;

   // Off time codes
   localparam logic [6:0] OFF_DISABLED     = 7'h00;
   localparam logic [6:0] OFF_ZERO_SEC     = 7'h01;
   localparam logic [6:0] OFF_FOREVER      = 7'h7F;

   // Timing
   localparam int unsigned CLK_PERIOD_NS    = 100;
   localparam int unsigned FADE_UNIT_MS     = 50;
   localparam int unsigned OFF_STEP_MS      = 100;
   localparam int unsigned FADE_UNIT_CYCLES = FADE_UNIT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned OFF_STEP_CYCLES  = OFF_STEP_MS * 1000000 / CLK_PERIOD_NS;
   // Longest time per code step, so rounded down
   localparam int unsigned FADE_STEP_CYCLES = FADE_UNIT_CYCLES / 127;

   typedef struct packed {
      logic       en;
      logic [7:0] addr;
      logic [7:0] data;
   } scfc_wr_t;

   typedef struct packed {
      logic       en;
      logic [7:0] addr;
   } scfc_rd_t;

   // Fade length in 50 ms units: 1..10 linear, then 15..35 in steps of 5
   function automatic logic [5:0] fade_units(input logic [3:0] code);
      logic [5:0] c;
      c = {2'h0, code};
      if (code <= FADE_LIN_LAST) begin
         return c;
      end
      return 6'(FADE_COARSE_BASE + FADE_COARSE_STEP * (c - FADE_COARSE_FROM));
   endfunction

   function automatic logic [31:0] fade_period(input logic [3:0] code,
                                               input int unsigned step);
      return 32'(fade_units(code)) * step;
   endfunction

endpackage

`default_nettype wire

// >>> hw/scfc_ramp.sv
/*
 * Current ramp for one sink: walks the output code toward a target one
 * code per step, with the step spacing set by the fade-in or fade-out code; a code of 0 jumps straight to the target.
 * Assumes target and codes come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module scfc_ramp #(
   parameter int unsigned STEP_CYCLES = scfc_pkg::FADE_STEP_CYCLES
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic [6:0] i_target,
   input  wire logic [3:0] i_fade_in,
   input  wire logic [3:0] i_fade_out,
   output logic      [6:0] o_level
);

   logic [6:0]  level_q, level_d;
   logic [31:0] cnt_q, cnt_d;
   logic        up, dn;
   logic [3:0]  code;
   logic [31:0] period;

   generate
      if (STEP_CYCLES < 1) begin : g_bad_step
         $error("STEP_CYCLES must be at least one");
      end
   endgenerate

   always_comb begin
      up      = i_target > level_q;
      dn      = i_target < level_q;
      code    = up ? i_fade_in : i_fade_out;
      period  = scfc_pkg::fade_period(code, STEP_CYCLES);
      level_d = level_q;
      cnt_d   = cnt_q;
      if (!up && !dn) begin
         cnt_d = 32'h0;
      end else if (code == scfc_pkg::FADE_DISABLED) begin
         level_d = i_target; // RL12
         cnt_d   = 32'h0;
      end else if (cnt_q >= period - 32'h1) begin
         // One code per step: 127 steps span full scale whatever range is set
         level_d = up ? level_q + 7'h01 : level_q - 7'h01; // RL3 RL6 RL7
         cnt_d   = 32'h0;
      end else begin
         cnt_d = cnt_q + 32'h1; // RL4
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         level_q <= 7'h00;
         cnt_q   <= 32'h0;
      end else begin
         level_q <= level_d;
         cnt_q   <= cnt_d;
      end
   end

   assign o_level = level_q;

   a_fade_in_step : assert property (@(posedge i_clk) disable iff (i_rst) // RL6
      (up && i_fade_in != scfc_pkg::FADE_DISABLED)
      |=> (level_q == $past(level_q) || level_q == $past(level_q) + 7'h01))
      else $error("fade-in moved more than one code");

   a_fade_out_step : assert property (@(posedge i_clk) disable iff (i_rst) // RL3
      (dn && i_fade_out != scfc_pkg::FADE_DISABLED)
      |=> (level_q == $past(level_q) || level_q == $past(level_q) - 7'h01))
      else $error("fade-out moved more than one code");

   a_no_fade_jump : assert property (@(posedge i_clk) disable iff (i_rst) // RL12
      (i_target != level_q && code == scfc_pkg::FADE_DISABLED)
      |=> level_q == $past(i_target))
      else $error("disabled fade did not jump");

   a_step_spacing : assert property (@(posedge i_clk) disable iff (i_rst) // RL4
      (level_q != $past(level_q) && code != scfc_pkg::FADE_DISABLED
       && i_target != level_q && period > 32'h1)
      |=> $stable(level_q))
      else $error("fade steps came too close");

endmodule

`default_nettype wire

// >>> hw/scfc_top.sv
/*
 * Sink fade and LED1 current control: holds the fade-time and LED1 current
 * registers, runs the LED1 on/off sequence and ramps the sink code.
 * Assumes register requests, sink enable, off-time code and the end of the
 * on phase come from logic on the same clock; no synchronisers needed.
 */
// Functional notes
// [RL1] Fade-out and fade-in codes share one 8-bit register at offset 0x22.
// [RL2] Bits 7:4 of that register pick the fade-out time used when ramping down.
// [RL3] A fade-out time is measured from full scale to zero, not from the present level.
// [RL4] Code 0 disables fading, 1 to 10 give 0.05 s to 0.50 s, 11 to 15 give 0.75 s to 1.75 s.
// [RL5] Bits 3:0 of that register pick the fade-in time used when ramping up.
// [RL6] A fade-in time is measured from zero to full scale with the same table.
// [RL7] Full scale is whatever the current range selects, so a fade spans that range.
// [RL8] Software should avoid a zero-second off time together with a zero fade-out.
// [RL9] The off-forever code holds the LED off so a blink sequence runs only once.
// [RL10] Offset 0x23 holds the LED1 current code in bits 6:0 with bit 7 reserved.
// [RL11] An enabled sink with the disabled off-time code stays on with no off phase.
// [RL12] With a disabled fade code the current changes to its new level in one step.
`timescale 1ns/1ps
`default_nettype none

module scfc_top #(
   parameter int unsigned FADE_STEP_CYCLES = scfc_pkg::FADE_STEP_CYCLES,
   parameter int unsigned OFF_STEP_CYCLES  = scfc_pkg::OFF_STEP_CYCLES
) (
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   input  wire scfc_pkg::scfc_wr_t i_wr,
   input  wire scfc_pkg::scfc_rd_t i_rd,
   input  wire logic              i_sink_en,
   input  wire logic [6:0]        i_sink_off_time,
   input  wire logic              i_on_done,
   output logic      [7:0]        o_rd_data,
   output logic                   o_rd_valid,
   output logic      [6:0]        o_sink_code,
   output logic                   o_sink_on,
   output logic                   o_sink_held_off
);

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ON   = 4'b0010,
      ST_OFF  = 4'b0100,
      ST_HOLD = 4'b1000
   } scfc_state_t;

   logic [7:0]  fade_q, fade_d;
   logic [6:0]  code_q, code_d;
   logic [7:0]  rdata_q, rdata_d;
   logic        rvalid_q, rvalid_d;
   scfc_state_t state_q, state_d;
   logic [31:0] off_cnt_q, off_cnt_d;
   logic [31:0] off_len;
   logic [6:0]  target;
   logic [3:0]  fade_out_code;
   logic [3:0]  fade_in_code;

   generate
      if (OFF_STEP_CYCLES < 1) begin : g_bad_off
         $error("OFF_STEP_CYCLES must be at least one");
      end
   endgenerate

   function automatic logic hit(input scfc_pkg::scfc_wr_t w, input logic [7:0] a);
      return w.en && (w.addr == a);
   endfunction

   // Register file
   always_comb begin
      fade_d = fade_q;
      code_d = code_q;
      if (hit(i_wr, scfc_pkg::ADDR_FADE_TIMES)) begin
         fade_d = i_wr.data; // RL1
      end
      if (hit(i_wr, scfc_pkg::ADDR_LED1_CURR)) begin
         code_d = i_wr.data[scfc_pkg::CURR_CODE_MSB:0]; // RL10
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         fade_q <= scfc_pkg::FADE_TIMES_RST;
         code_q <= scfc_pkg::LED1_CODE_RST;
      end else begin
         fade_q <= fade_d;
         code_q <= code_d;
      end
   end

   assign fade_out_code = fade_q[scfc_pkg::FADE_OUT_MSB:scfc_pkg::FADE_OUT_LSB]; // RL2
   assign fade_in_code  = fade_q[scfc_pkg::FADE_IN_MSB:scfc_pkg::FADE_IN_LSB];   // RL5

   // Read port, one cycle latency; unmapped offsets read zero
   always_comb begin
      rvalid_d = i_rd.en;
      rdata_d  = rdata_q;
      if (i_rd.en) begin
         case (i_rd.addr)
            scfc_pkg::ADDR_FADE_TIMES: begin
               rdata_d = fade_q;
            end
            scfc_pkg::ADDR_LED1_CURR: begin
               rdata_d = {1'b0, code_q}; // RL10
            end
            default: begin
               rdata_d = scfc_pkg::RDATA_UNMAPPED;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rdata_q  <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // On/off sequencer
   // Code 1 means zero seconds off: with fade-out also zero the LED never
   // visibly goes dark, which is why software should avoid that pair.
   always_comb begin
      off_len   = 32'(i_sink_off_time - 7'h01) * OFF_STEP_CYCLES;
      state_d   = state_q;
      off_cnt_d = off_cnt_q;
      if (!i_sink_en) begin
         state_d   = ST_IDLE;
         off_cnt_d = 32'h0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               state_d = ST_ON;
            end
            ST_ON: begin
               if (i_on_done && i_sink_off_time != scfc_pkg::OFF_DISABLED) begin // RL11
                  off_cnt_d = 32'h0;
                  if (i_sink_off_time == scfc_pkg::OFF_FOREVER) begin
                     state_d = ST_HOLD; // RL9
                  end else begin
                     state_d = ST_OFF; // RL8
                  end
               end
            end
            ST_OFF: begin
               if (off_cnt_q >= off_len) begin
                  state_d   = ST_ON;
                  off_cnt_d = 32'h0;
               end else begin
                  off_cnt_d = off_cnt_q + 32'h1;
               end
            end
            ST_HOLD: begin
               state_d = ST_HOLD; // RL9
            end
            default: begin
               state_d   = ST_IDLE;
               off_cnt_d = 32'h0;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q   <= ST_IDLE;
         off_cnt_q <= 32'h0;
      end else begin
         state_q   <= state_d;
         off_cnt_q <= off_cnt_d;
      end
   end

   // Ramp toward the programmed code while on, toward zero otherwise
   assign target = (state_q == ST_ON) ? code_q : 7'h00;

   scfc_ramp #(
      .STEP_CYCLES (FADE_STEP_CYCLES)
   ) u_ramp (
      .i_clk      (i_clk),
      .i_rst      (i_rst),
      .i_target   (target),
      .i_fade_in  (fade_in_code),
      .i_fade_out (fade_out_code),
      .o_level    (o_sink_code)
   );

   assign o_rd_data       = rdata_q;
   assign o_rd_valid      = rvalid_q;
   assign o_sink_on       = state_q[1];
   assign o_sink_held_off = state_q[3];

   sequence s_fade_write;
      i_wr.en && i_wr.addr == scfc_pkg::ADDR_FADE_TIMES;
   endsequence

   sequence s_curr_read;
      i_rd.en && i_rd.addr == scfc_pkg::ADDR_LED1_CURR;
   endsequence

   sequence s_curr_write;
      i_wr.en && i_wr.addr == scfc_pkg::ADDR_LED1_CURR;
   endsequence

   sequence s_fade_read;
      i_rd.en && i_rd.addr == scfc_pkg::ADDR_FADE_TIMES;
   endsequence

   sequence s_other_read;
      i_rd.en && i_rd.addr != scfc_pkg::ADDR_FADE_TIMES
      && i_rd.addr != scfc_pkg::ADDR_LED1_CURR;
   endsequence

   sequence s_other_write;
      i_wr.en && i_wr.addr != scfc_pkg::ADDR_FADE_TIMES
      && i_wr.addr != scfc_pkg::ADDR_LED1_CURR;
   endsequence

   // A timed off phase, neither continuous nor held forever
   sequence s_enter_off;
      state_q == ST_ON && i_sink_en && i_on_done
      && i_sink_off_time != scfc_pkg::OFF_DISABLED
      && i_sink_off_time != scfc_pkg::OFF_FOREVER;
   endsequence

   a_fade_reg_write : assert property (@(posedge i_clk) disable iff (i_rst) // RL1
      s_fade_write |=> fade_q == $past(i_wr.data))
      else $error("fade register write lost");

   a_fade_out_field : assert property (@(posedge i_clk) disable iff (i_rst) // RL2
      s_fade_write |=> fade_out_code == $past(i_wr.data[7:4]))
      else $error("fade-out field not from upper nibble");

   a_fade_in_field : assert property (@(posedge i_clk) disable iff (i_rst) // RL5
      s_fade_write |=> fade_in_code == $past(i_wr.data[3:0]))
      else $error("fade-in field not from lower nibble");

   a_curr_readback : assert property (@(posedge i_clk) disable iff (i_rst) // RL10
      s_curr_read |=> o_rd_valid && o_rd_data == {1'b0, $past(code_q)})
      else $error("current register read back wrong");

   a_stay_on : assert property (@(posedge i_clk) disable iff (i_rst) // RL11
      (state_q == ST_ON && i_sink_en && i_sink_off_time == scfc_pkg::OFF_DISABLED)
      |=> state_q == ST_ON)
      else $error("sink left on state with off time disabled");

   a_hold_forever : assert property (@(posedge i_clk) disable iff (i_rst) // RL9
      (state_q == ST_ON && i_sink_en && i_on_done
       && i_sink_off_time == scfc_pkg::OFF_FOREVER)
      |=> o_sink_held_off ##1 (o_sink_held_off || !$past(i_sink_en)))
      else $error("off-forever code did not hold the sink off");

   a_off_target : assert property (@(posedge i_clk) disable iff (i_rst) // RL9
      (state_q == ST_HOLD && fade_out_code == scfc_pkg::FADE_DISABLED)
      |=> o_sink_code == 7'h00)
      else $error("held-off sink still drives current");

   a_zero_off_time : assert property (@(posedge i_clk) disable iff (i_rst) // RL8
      (state_q == ST_OFF && i_sink_en && i_sink_off_time == scfc_pkg::OFF_ZERO_SEC)
      |=> state_q == ST_ON)
      else $error("zero off time did not return at once");

   a_curr_reg_write : assert property (@(posedge i_clk) disable iff (i_rst) // RL10
      s_curr_write |=> code_q == $past(i_wr.data[6:0]))
      else $error("current register write lost");

   a_fade_readback : assert property (@(posedge i_clk) disable iff (i_rst) // RL1
      s_fade_read |=> o_rd_valid && o_rd_data == $past(fade_q))
      else $error("fade register read back wrong");

   a_unmapped_read : assert property (@(posedge i_clk) disable iff (i_rst) // RL1
      s_other_read |=> o_rd_valid && o_rd_data == scfc_pkg::RDATA_UNMAPPED)
      else $error("unmapped offset did not read zero");

   a_write_no_alias : assert property (@(posedge i_clk) disable iff (i_rst) // RL1
      s_other_write |=> $stable(fade_q) && $stable(code_q))
      else $error("unmapped write changed a register");

   a_rd_pulse : assert property (@(posedge i_clk) disable iff (i_rst) // RL10
      !i_rd.en |=> !o_rd_valid)
      else $error("read valid without a read request");

   a_enable_on : assert property (@(posedge i_clk) disable iff (i_rst) // RL11
      (state_q == ST_IDLE && i_sink_en)
      |=> o_sink_on)
      else $error("enabled sink did not turn on");

   a_disable_idle : assert property (@(posedge i_clk) disable iff (i_rst) // RL9
      !i_sink_en
      |=> state_q == ST_IDLE && !o_sink_held_off)
      else $error("disabled sink did not return to idle");

   a_off_entry : assert property (@(posedge i_clk) disable iff (i_rst) // RL9
      s_enter_off |=> state_q == ST_OFF && !o_sink_on)
      else $error("timed off phase not entered");

   a_off_length : assert property (@(posedge i_clk) disable iff (i_rst) // RL9
      (state_q == ST_OFF && i_sink_en && off_cnt_q < off_len)
      |=> state_q == ST_OFF)
      else $error("off phase ended early");

   a_on_jump : assert property (@(posedge i_clk) disable iff (i_rst) // RL12
      (state_q == ST_ON && fade_in_code == scfc_pkg::FADE_DISABLED && o_sink_code < code_q)
      |=> o_sink_code == $past(code_q))
      else $error("disabled fade-in did not jump to the code");

   a_off_fade_jump : assert property (@(posedge i_clk) disable iff (i_rst) // RL12
      (state_q != ST_ON && fade_out_code == scfc_pkg::FADE_DISABLED)
      |=> o_sink_code == 7'h00)
      else $error("disabled fade-out did not drop to zero");

endmodule

`default_nettype wire
